// ---- rtl/sbt_tap.sv ----
// boundary-scan test access port of the synchronous sram
// Notes on behaviour
// - code 000 captures the pin ring into the scan register on capture-dr.
// - code 001 selects the 32-bit identification register; memory unaffected.
// - code 010 captures pins, selects the 109-bit ring, floats memory outputs.
// - code 100 captures pins and selects the ring; memory unaffected.
// - code 111 selects the one-bit bypass register; memory unaffected.
// - identification holds revision 31:29, part 28:12, maker 11:1, fixed.
// - identification bit 0 always reads one.
// - tdo changes after the falling tck edge.
// - tms and tdi are sampled on rising tck.
// - cell 108 gates the output drivers while extest is current.
// - identification is the current instruction after test-logic-reset.
// - a shifted instruction takes effect only on update-ir.
// - the top cell sits at tdi, cell zero at tdo.
module sbt_tap #(
  parameter logic [2:0]  ID_REV  = sbt_pkg::ID_REV_DEFAULT,
  parameter logic [16:0] ID_PART = sbt_pkg::ID_PART_DEFAULT,
  parameter logic [10:0] ID_MFR  = sbt_pkg::ID_MFR_DEFAULT
) (
  // system clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          reset,
  // test link
  input  wire logic                          tck,
  input  wire logic                          tms,
  input  wire logic                          tdi,
  output logic                               tdo,
  output logic                               tdo_oe,
  // pin ring, from the system domain, sampled on rising tck
  input  wire logic [sbt_pkg::BSR_WIDTH-1:0] ring_pins,
  // pin ring drive, in the system domain
  output logic [sbt_pkg::BSR_WIDTH-1:0]      ring_drive,
  output logic                               ring_extest,
  output logic                               mem_out_en
);
  localparam int BW = sbt_pkg::BSR_WIDTH;

  // tap reset: forced in the tck domain by system reset via a two-stage sync
  logic tck_rst_meta_reg;
  logic tck_rst_reg;
  always_ff @(posedge tck) begin
    tck_rst_meta_reg <= reset;
    tck_rst_reg      <= tck_rst_meta_reg;
  end

  // pins come from the system domain; held two flops in tck before capture
  logic [BW-1:0] pins_meta_reg;
  logic [BW-1:0] pins_sync_reg;
  always_ff @(posedge tck) begin
    pins_meta_reg <= ring_pins;
    pins_sync_reg <= pins_meta_reg;
  end

  sbt_pkg::sbt_tap_state_t state;
  sbt_tap_fsm u_fsm (
    .tck     (tck),
    .tap_rst (tck_rst_reg),
    .tms     (tms),
    .state   (state)
  );

  logic [2:0]    ir_shift_reg;
  logic [2:0]    ir_reg;
  logic          byp_reg;
  logic [31:0]   id_reg;
  logic [BW-1:0] bsr_reg;
  logic [BW-1:0] preload_reg;
  logic          tdo_reg;
  logic          tdo_oe_reg;

  function automatic logic [31:0] id_word(input logic [2:0] rev, input logic [16:0] part,
                                           input logic [10:0] mfr);
    logic [31:0] w;
    w = 32'h0;
    w[sbt_pkg::ID_REV_MSB:sbt_pkg::ID_REV_LSB]   = rev;
    w[sbt_pkg::ID_PART_MSB:sbt_pkg::ID_PART_LSB] = part;
    w[sbt_pkg::ID_MFR_MSB:sbt_pkg::ID_MFR_LSB]   = mfr;
    w[sbt_pkg::ID_PRESENT_BIT]                   = sbt_pkg::ID_PRESENT;
    return w;
  endfunction : id_word

  function automatic logic sel_ring(input logic [2:0] ir);
    return ir == sbt_pkg::IR_EXTEST || ir == sbt_pkg::IR_CAPFLOAT ||
           ir == sbt_pkg::IR_SAMPLE;
  endfunction : sel_ring

  always_ff @(posedge tck) begin
    if (tck_rst_reg) begin
      ir_shift_reg <= sbt_pkg::IR_RESET_VAL;
    end else if (state == sbt_pkg::TAP_CAP_IR) begin
      ir_shift_reg <= {1'b0, sbt_pkg::IR_CAPTURE_VAL};
    end else if (state == sbt_pkg::TAP_SHIFT_IR) begin
      ir_shift_reg <= {tdi, ir_shift_reg[2:1]};
    end
  end

  always_ff @(posedge tck) begin
    if (tck_rst_reg || state == sbt_pkg::TAP_RESET) begin
      ir_reg <= sbt_pkg::IR_RESET_VAL;
    end else if (state == sbt_pkg::TAP_UPD_IR) begin
      // reserved codes are loaded as-is and select bypass
      ir_reg <= ir_shift_reg;
    end
  end

  always_ff @(posedge tck) begin
    if (tck_rst_reg) begin
      byp_reg <= 1'b0;
    end else if (state == sbt_pkg::TAP_CAP_DR) begin
      byp_reg <= 1'b0;
    end else if (state == sbt_pkg::TAP_SHIFT_DR) begin
      byp_reg <= tdi;
    end
  end

  always_ff @(posedge tck) begin
    if (tck_rst_reg) begin
      id_reg <= 32'h0;
    end else if (state == sbt_pkg::TAP_CAP_DR && ir_reg == sbt_pkg::IR_IDCODE) begin
      id_reg <= id_word(ID_REV, ID_PART, ID_MFR);
    end else if (state == sbt_pkg::TAP_SHIFT_DR && ir_reg == sbt_pkg::IR_IDCODE) begin
      id_reg <= {tdi, id_reg[31:1]};
    end
  end

  always_ff @(posedge tck) begin
    if (tck_rst_reg) begin
      bsr_reg <= '0;
    end else if (state == sbt_pkg::TAP_CAP_DR && sel_ring(ir_reg)) begin
      bsr_reg <= pins_sync_reg;
    end else if (state == sbt_pkg::TAP_SHIFT_DR && sel_ring(ir_reg)) begin
      // msb at tdi, lsb at tdo
      bsr_reg <= {tdi, bsr_reg[BW-1:1]};
    end
  end

  always_ff @(posedge tck) begin
    if (tck_rst_reg || state == sbt_pkg::TAP_RESET) begin
      preload_reg <= '0;
    end else if (state == sbt_pkg::TAP_UPD_DR && sel_ring(ir_reg)) begin
      preload_reg <= bsr_reg;
    end
  end

  // serial mux, sampled on the falling edge
  logic tdo_mux;
  logic shifting;
  always_comb begin
    shifting = state == sbt_pkg::TAP_SHIFT_DR || state == sbt_pkg::TAP_SHIFT_IR;
    if (state == sbt_pkg::TAP_SHIFT_IR) begin
      tdo_mux = ir_shift_reg[0];
    end else if (ir_reg == sbt_pkg::IR_IDCODE) begin
      tdo_mux = id_reg[0];
    end else if (sel_ring(ir_reg)) begin
      tdo_mux = bsr_reg[0];
    end else begin
      tdo_mux = byp_reg;
    end
  end

  always_ff @(negedge tck) begin
    if (tck_rst_reg) begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else begin
      tdo_reg    <= tdo_mux;
      tdo_oe_reg <= shifting;
    end
  end
  assign tdo    = tdo_reg;
  assign tdo_oe = tdo_oe_reg;

  // controls toward the system domain: decoded into flops so the sync never sees a glitch
  logic          ext_tck_reg;
  logic          float_tck_reg;
  always_ff @(posedge tck) begin
    if (tck_rst_reg || state == sbt_pkg::TAP_RESET) begin
      ext_tck_reg   <= 1'b0;
      float_tck_reg <= 1'b0;
    end else if (state == sbt_pkg::TAP_UPD_IR) begin
      ext_tck_reg   <= ir_shift_reg == sbt_pkg::IR_EXTEST;
      float_tck_reg <= ir_shift_reg == sbt_pkg::IR_CAPFLOAT;
    end
  end

  // preload handed over by toggle
  // the toggle flips with every change of the latch, which then holds still while copied
  logic preload_tgl_reg;
  always_ff @(posedge tck) begin
    if (tck_rst_reg) begin
      preload_tgl_reg <= 1'b0;
    end else if (state == sbt_pkg::TAP_RESET && preload_reg != '0) begin
      preload_tgl_reg <= ~preload_tgl_reg;
    end else if (state == sbt_pkg::TAP_UPD_DR && sel_ring(ir_reg)) begin
      preload_tgl_reg <= ~preload_tgl_reg;
    end
  end

  logic [1:0]    ext_sync_reg;
  logic [1:0]    float_sync_reg;
  logic [2:0]    tgl_sync_reg;
  logic [BW-1:0] drv_reg;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ext_sync_reg   <= 2'h0;
      float_sync_reg <= 2'h0;
      tgl_sync_reg   <= 3'h0;
    end else begin
      ext_sync_reg   <= {ext_sync_reg[0], ext_tck_reg};
      float_sync_reg <= {float_sync_reg[0], float_tck_reg};
      tgl_sync_reg   <= {tgl_sync_reg[1:0], preload_tgl_reg};
    end
  end

  // copy after the toggle has passed two flops; limitation: the latch must then
  // hold for three system cycles, which a tck at or under 20 MHz always gives
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      drv_reg <= '0;
    end else if (tgl_sync_reg[2] != tgl_sync_reg[1]) begin
      drv_reg <= preload_reg;
    end
  end

  logic mem_oe_reg;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mem_oe_reg <= 1'b1;
    end else if (float_sync_reg[1]) begin
      mem_oe_reg <= 1'b0;
    end else if (ext_sync_reg[1]) begin
      mem_oe_reg <= drv_reg[sbt_pkg::BSR_OE_BIT];
    end else begin
      mem_oe_reg <= 1'b1;
    end
  end

  assign mem_out_en  = mem_oe_reg;
  assign ring_extest = ext_sync_reg[1];
  assign ring_drive  = drv_reg;

  AST_ID_PRESENT: assert property (@(posedge tck) disable iff (tck_rst_reg)
    state == sbt_pkg::TAP_CAP_DR && ir_reg == sbt_pkg::IR_IDCODE |=> id_reg[0] == 1'b1)
    else $error("id presence bit not one after capture");
  AST_ID_FIELDS: assert property (@(posedge tck) disable iff (tck_rst_reg)
    state == sbt_pkg::TAP_CAP_DR && ir_reg == sbt_pkg::IR_IDCODE |=>
      id_reg[31:29] == ID_REV && id_reg[28:12] == ID_PART && id_reg[11:1] == ID_MFR)
    else $error("id fields wrong after capture");
  AST_IR_HOLD: assert property (@(posedge tck) disable iff (tck_rst_reg)
    state != sbt_pkg::TAP_UPD_IR && state != sbt_pkg::TAP_RESET |=> $stable(ir_reg))
    else $error("instruction changed outside update-ir");
  AST_IR_RESET: assert property (@(posedge tck) disable iff (tck_rst_reg)
    state == sbt_pkg::TAP_RESET |=> ir_reg == sbt_pkg::IR_IDCODE)
    else $error("instruction not identification after reset state");
  AST_RING_CAPTURE: assert property (@(posedge tck) disable iff (tck_rst_reg)
    state == sbt_pkg::TAP_CAP_DR && sel_ring(ir_reg) |=> bsr_reg == $past(pins_sync_reg))
    else $error("ring capture mismatch");
  AST_RING_SHIFT: assert property (@(posedge tck) disable iff (tck_rst_reg)
    state == sbt_pkg::TAP_SHIFT_DR && sel_ring(ir_reg) |=>
      bsr_reg[BW-1] == $past(tdi) && bsr_reg[BW-2:0] == $past(bsr_reg[BW-1:1]))
    else $error("ring shift direction wrong");
  AST_BYPASS: assert property (@(posedge tck) disable iff (tck_rst_reg)
    state == sbt_pkg::TAP_SHIFT_DR |=> byp_reg == $past(tdi))
    else $error("bypass cell did not take tdi");
  AST_TDO_FALL: assert property (@(negedge tck) disable iff (tck_rst_reg)
    state == sbt_pkg::TAP_SHIFT_DR && ir_reg == sbt_pkg::IR_BYPASS |=> tdo == $past(byp_reg))
    else $error("tdo did not follow bypass on falling edge");
  AST_FLOAT: assert property (@(posedge sys_clk) disable iff (reset)
    float_sync_reg[1] |=> !mem_out_en)
    else $error("outputs not floated under capture-and-float");
  AST_NO_FLOAT_SAMPLE: assert property (@(posedge sys_clk) disable iff (reset)
    !float_sync_reg[1] && !ext_sync_reg[1] |=> mem_out_en)
    else $error("outputs disturbed outside test modes");
  AST_IR_CAPTURE: assert property (@(posedge tck) disable iff (tck_rst_reg)
    state == sbt_pkg::TAP_CAP_IR |=> ir_shift_reg == {1'b0, sbt_pkg::IR_CAPTURE_VAL})
    else $error("instruction capture value wrong");
  AST_ID_SHIFT: assert property (@(posedge tck) disable iff (tck_rst_reg)
    state == sbt_pkg::TAP_SHIFT_DR && ir_reg == sbt_pkg::IR_IDCODE |=> id_reg[31] == $past(tdi))
    else $error("identification register did not take tdi");
  AST_TDO_OE: assert property (@(negedge tck) disable iff (tck_rst_reg)
    shifting |=> tdo_oe)
    else $error("tdo not enabled while shifting");
  AST_DRV_COPY: assert property (@(posedge sys_clk) disable iff (reset)
    tgl_sync_reg[2] != tgl_sync_reg[1] |=> ring_drive == $past(preload_reg))
    else $error("preload word not copied to the system side");
  AST_EXT_OE: assert property (@(posedge sys_clk) disable iff (reset)
    ext_sync_reg[1] && !float_sync_reg[1] |=> mem_out_en == $past(drv_reg[sbt_pkg::BSR_OE_BIT]))
    else $error("output enable does not follow the control cell");
endmodule : sbt_tap

// ---- pkg/sbt_pkg.sv ----
// package for the sram boundary-scan test access port
package sbt_pkg;
  localparam int IR_WIDTH = 3;
  localparam int ID_WIDTH = 32;
  localparam int BSR_WIDTH = 109;
  localparam int BSR_OE_BIT = 108;
  localparam logic [2:0] IR_EXTEST = 3'h0;
  localparam logic [2:0] IR_IDCODE = 3'h1;
  localparam logic [2:0] IR_CAPFLOAT = 3'h2;
  localparam logic [2:0] IR_SAMPLE = 3'h4;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  localparam logic [2:0] IR_RESET_VAL = IR_IDCODE;
  localparam logic [1:0] IR_CAPTURE_VAL = 2'h1;
  localparam int ID_REV_MSB = 31;
  localparam int ID_REV_LSB = 29;
  localparam int ID_PART_MSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MFR_MSB = 11;
  localparam int ID_MFR_LSB = 1;
  localparam int ID_PRESENT_BIT = 0;
  // arbitrary identity values
  localparam logic [2:0] ID_REV_DEFAULT = 3'h0;
  localparam logic [16:0] ID_PART_DEFAULT = 17'h0_1234;
  localparam logic [10:0] ID_MFR_DEFAULT = 11'h055;
  localparam logic ID_PRESENT = 1'b1;
  localparam int TCK_MIN_PERIOD_NS = 50;
  localparam int TCK_MAX_FREQ_MHZ = 20;
  localparam int SYS_CLK_MHZ = 20;
  localparam int SYS_PERIOD_NS = 1000 / SYS_CLK_MHZ;
  localparam int TCK_MIN_CYCLES = (TCK_MIN_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  typedef enum logic [15:0] {
    TAP_RESET      = 16'h0001,
    TAP_IDLE       = 16'h0002,
    TAP_SEL_DR     = 16'h0004,
    TAP_CAP_DR     = 16'h0008,
    TAP_SHIFT_DR   = 16'h0010,
    TAP_EXIT1_DR   = 16'h0020,
    TAP_PAUSE_DR   = 16'h0040,
    TAP_EXIT2_DR   = 16'h0080,
    TAP_UPD_DR     = 16'h0100,
    TAP_SEL_IR     = 16'h0200,
    TAP_CAP_IR     = 16'h0400,
    TAP_SHIFT_IR   = 16'h0800,
    TAP_EXIT1_IR   = 16'h1000,
    TAP_PAUSE_IR   = 16'h2000,
    TAP_EXIT2_IR   = 16'h4000,
    TAP_UPD_IR     = 16'h8000
  } sbt_tap_state_t;
endpackage : sbt_pkg

// ---- rtl/sbt_tap_fsm.sv ----
// tap controller state machine, advancing on rising tck
module sbt_tap_fsm (
  // link clock and tap reset
  input  wire logic           tck,
  input  wire logic           tap_rst,
  // mode select
  input  wire logic           tms,
  // state
  output sbt_pkg::sbt_tap_state_t state
);
  sbt_pkg::sbt_tap_state_t state_reg;
  sbt_pkg::sbt_tap_state_t state_next;

  always_comb begin
    unique case (state_reg)
      sbt_pkg::TAP_RESET:    state_next = tms ? sbt_pkg::TAP_RESET   : sbt_pkg::TAP_IDLE;
      sbt_pkg::TAP_IDLE:     state_next = tms ? sbt_pkg::TAP_SEL_DR  : sbt_pkg::TAP_IDLE;
      sbt_pkg::TAP_SEL_DR:   state_next = tms ? sbt_pkg::TAP_SEL_IR  : sbt_pkg::TAP_CAP_DR;
      sbt_pkg::TAP_CAP_DR:   state_next = tms ? sbt_pkg::TAP_EXIT1_DR : sbt_pkg::TAP_SHIFT_DR;
      sbt_pkg::TAP_SHIFT_DR: state_next = tms ? sbt_pkg::TAP_EXIT1_DR : sbt_pkg::TAP_SHIFT_DR;
      sbt_pkg::TAP_EXIT1_DR: state_next = tms ? sbt_pkg::TAP_UPD_DR  : sbt_pkg::TAP_PAUSE_DR;
      sbt_pkg::TAP_PAUSE_DR: state_next = tms ? sbt_pkg::TAP_EXIT2_DR : sbt_pkg::TAP_PAUSE_DR;
      sbt_pkg::TAP_EXIT2_DR: state_next = tms ? sbt_pkg::TAP_UPD_DR  : sbt_pkg::TAP_SHIFT_DR;
      sbt_pkg::TAP_UPD_DR:   state_next = tms ? sbt_pkg::TAP_SEL_DR  : sbt_pkg::TAP_IDLE;
      sbt_pkg::TAP_SEL_IR:   state_next = tms ? sbt_pkg::TAP_RESET   : sbt_pkg::TAP_CAP_IR;
      sbt_pkg::TAP_CAP_IR:   state_next = tms ? sbt_pkg::TAP_EXIT1_IR : sbt_pkg::TAP_SHIFT_IR;
      sbt_pkg::TAP_SHIFT_IR: state_next = tms ? sbt_pkg::TAP_EXIT1_IR : sbt_pkg::TAP_SHIFT_IR;
      sbt_pkg::TAP_EXIT1_IR: state_next = tms ? sbt_pkg::TAP_UPD_IR  : sbt_pkg::TAP_PAUSE_IR;
      sbt_pkg::TAP_PAUSE_IR: state_next = tms ? sbt_pkg::TAP_EXIT2_IR : sbt_pkg::TAP_PAUSE_IR;
      sbt_pkg::TAP_EXIT2_IR: state_next = tms ? sbt_pkg::TAP_UPD_IR  : sbt_pkg::TAP_SHIFT_IR;
      sbt_pkg::TAP_UPD_IR:   state_next = tms ? sbt_pkg::TAP_SEL_DR  : sbt_pkg::TAP_IDLE;
      // a corrupted one-hot code falls back to reset
      default:               state_next = sbt_pkg::TAP_RESET;
    endcase
  end

  always_ff @(posedge tck) begin
    if (tap_rst) begin
      state_reg <= sbt_pkg::TAP_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign state = state_reg;

  AST_FIVE_ONES_RESET: assert property (@(posedge tck) disable iff (tap_rst)
    tms [*5] |=> state_reg == sbt_pkg::TAP_RESET)
    else $error("five tms highs did not reach reset");
  AST_UPDIR_NEXT: assert property (@(posedge tck) disable iff (tap_rst)
    state_reg == sbt_pkg::TAP_EXIT1_IR && tms |=> state_reg == sbt_pkg::TAP_UPD_IR)
    else $error("exit1-ir with tms high did not go to update-ir");
endmodule : sbt_tap_fsm

// ---- dv/sbt_jtag_ctrl.sv ----
// test controller model that drives the tap link
module sbt_jtag_ctrl (
  // link
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // 60 ns cycle, above the 50 ns floor
  localparam time HALF = 30ns;
  logic oe_s;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    oe_s = 1'b0;
  end
  // inputs set while tck low, held over the rise
  task automatic cyc(input logic m, input logic d, input logic use_d, output logic q);
    tms = m;
    // idle data line toggles so a stale bit is never mistaken for valid
    tdi = use_d ? d : ~tdi;
    #HALF;
    q = tdo;
    oe_s = tdo_oe;
    tck = 1'b1;
    #HALF;
    tck = 1'b0;
  endtask : cyc
  // five ones reach test-logic-reset, then idle
  task automatic tap_reset();
    logic q;
    repeat (5) cyc(1'b1, 1'b0, 1'b0, q);
    cyc(1'b0, 1'b0, 1'b0, q);
  endtask : tap_reset
  // idle to shift, n bits lsb first, update, idle
  task automatic shift(input logic ir, input int n, input logic [108:0] din,
                       output logic [108:0] dout, output logic oe);
    logic q;
    dout = '0;
    oe = 1'b1;
    cyc(1'b1, 1'b0, 1'b0, q);
    if (ir) cyc(1'b1, 1'b0, 1'b0, q);
    cyc(1'b0, 1'b0, 1'b0, q);
    cyc(1'b0, 1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      cyc(1'(i == n - 1), din[i], 1'b1, q);
      dout[i] = q;
      oe = oe & oe_s;
    end
    cyc(1'b1, 1'b0, 1'b0, q);
    cyc(1'b0, 1'b0, 1'b0, q);
  endtask : shift
endmodule : sbt_jtag_ctrl

// ---- dv/sbt_tap_tb.sv ----
// self-checking bench for the boundary-scan access port
module sbt_tap_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0] code;
    logic [1:0] kind;
    logic       mem_en;
  } sbt_row_t;
  localparam logic [108:0] PINS = {1'b0, {9{12'hA5C}}};
  localparam logic [108:0] DIN  = {1'b1, {9{12'h3C9}}};
  // fields in place, presence bit set
  localparam logic [31:0] ID_EXP = {sbt_pkg::ID_REV_DEFAULT, sbt_pkg::ID_PART_DEFAULT,
                                    sbt_pkg::ID_MFR_DEFAULT, 1'b1};
  localparam int LIMIT = 20000;
  sbt_row_t rows [5] = '{'{sbt_pkg::IR_SAMPLE, 2'h0, 1'b1}, '{sbt_pkg::IR_IDCODE, 2'h1, 1'b1},
                         '{sbt_pkg::IR_BYPASS, 2'h2, 1'b1}, '{sbt_pkg::IR_CAPFLOAT, 2'h0, 1'b0},
                         '{sbt_pkg::IR_EXTEST, 2'h0, 1'b1}};
  logic           sys_clk;
  logic           reset;
  logic           tck;
  logic           tms;
  logic           tdi;
  logic           tdo;
  logic           tdo_oe;
  logic [108:0]   ring_pins;
  logic [108:0]   ring_drive;
  logic           ring_extest;
  logic           mem_out_en;
  logic [108:0]   dout;
  logic [108:0]   exp;
  logic           oe;
  logic           q;
  int             failures;
  int             samples_checked;
  int             cycles;
  sbt_tap u_dut (.sys_clk(sys_clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi),
                 .tdo(tdo), .tdo_oe(tdo_oe), .ring_pins(ring_pins), .ring_drive(ring_drive),
                 .ring_extest(ring_extest), .mem_out_en(mem_out_en));
  sbt_jtag_ctrl u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;
  task automatic chk(input string name, input logic [108:0] e, input logic [108:0] s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", name, e, s);
    end
  endtask : chk
  task automatic chkb(input string name, input logic e, input logic s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %b seen %b", name, e, s);
    end
  endtask : chkb
  task automatic test_done();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic settle();
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle
  // tdo only moves while tck is low
  always @(tdo) if (reset === 1'b0) chkb("tdo_phase", 1'b0, tck);
  // hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      test_done();
    end
  end
  initial begin
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    reset = 1'b1;
    ring_pins = PINS;
    // tck edges are needed while reset is held, the tap reset syncs on them
    fork
      u_ctl.tap_reset();
      repeat (6) @(negedge sys_clk);
    join
    @(negedge sys_clk);
    reset = 1'b0;
    u_ctl.tap_reset();
    settle();
    chk("ring_drive_rst", '0, ring_drive);
    chkb("mem_out_en_rst", 1'b1, mem_out_en);
    chkb("tdo_oe_rst", 1'b0, tdo_oe);
    for (int r = 0; r < 5; r++) begin
      u_ctl.shift(1'b1, 3, {106'h0, rows[r].code}, dout, oe);
      u_ctl.shift(1'b0, 109, DIN, dout, oe);
      settle();
      case (rows[r].kind)
        2'h0: exp = PINS;
        2'h1: exp = {DIN[76:0], ID_EXP};
        default: exp = {DIN[107:0], 1'b0};
      endcase
      chk("dr_out", exp, dout);
      chkb("tdo_oe", 1'b1, oe);
      chkb("tdo_oe_idle", 1'b0, tdo_oe);
      chkb("mem_out_en", rows[r].mem_en, mem_out_en);
      chkb("ring_extest", 1'(rows[r].code == sbt_pkg::IR_EXTEST), ring_extest);
      if (rows[r].kind == 2'h0) chk("ring_drive", DIN, ring_drive);
    end
    // output control cell low under extest floats the bus
    u_ctl.shift(1'b0, 109, {1'b0, DIN[107:0]}, dout, oe);
    settle();
    chkb("mem_float", 1'b0, mem_out_en);
    // park in pause-ir with a new code: the old one must stay current
    repeat (2) u_ctl.cyc(1'b1, 1'b0, 1'b0, q);
    repeat (2) u_ctl.cyc(1'b0, 1'b0, 1'b0, q);
    u_ctl.cyc(1'b0, 1'b1, 1'b1, q);
    u_ctl.cyc(1'b0, 1'b1, 1'b1, q);
    u_ctl.cyc(1'b1, 1'b1, 1'b1, q);
    repeat (4) u_ctl.cyc(1'b0, 1'b0, 1'b0, q);
    settle();
    chkb("extest_pause", 1'b1, ring_extest);
    repeat (2) u_ctl.cyc(1'b1, 1'b0, 1'b0, q);
    u_ctl.cyc(1'b0, 1'b0, 1'b0, q);
    settle();
    chkb("extest_upd", 1'b0, ring_extest);
    // back to extest, then test-logic-reset restores identification
    u_ctl.shift(1'b1, 3, 109'h0, dout, oe);
    u_ctl.tap_reset();
    u_ctl.shift(1'b0, 109, DIN, dout, oe);
    settle();
    chk("id_after_rst", {DIN[76:0], ID_EXP}, dout);
    chkb("extest_rst", 1'b0, ring_extest);
    chk("ring_drive_tlr", '0, ring_drive);
    test_done();
  end
endmodule : sbt_tap_tb
